// ### emr_cfg.svh
/*
 Constants of the receive client port and flow-control block: field
 positions, reset values, offsets and timing counts.
 Assumes it is included once per compilation unit by its bare name.
*/
//
// Notes on behaviour
// - Received frames leave as eight-bit bytes, each qualified by valid.
// - The last-marker rises with the final byte of every frame.
// - The error flag rises at frame end when the frame had an error.
// - One flag per frame filter lets the client keep its frames.
// - A 28-bit statistics vector describes the latest received frame.
// - A statistics valid pulse at frame end marks the vector as valid.
// - With audio-video support, a second byte stream with own flags.
// - Valid received flow-control frames are handled here when enabled.
// - An accepted pause frame holds the transmitter for its quanta.
// - An acted-on pause frame still reaches the client flagged bad.
// - A pause request sends a pause frame after the current frame.
// - The request's 16-bit value goes into the pause frame parameter.
// - All stream, sideband and flow-control signals are active high.
// - Management addresses are 17 bits with audio-video, else 12.
// - Management data is 32 bits and reaches configuration and status.
// - The management port has its own active-low synchronous reset.
// - No management port: receive setup comes from an 80-bit vector.
// - No management port: transmit setup comes from an 80-bit vector.
// - Configuration vector bits are registered on input, may be async.
// - MAC clock scales with line rate: one byte per clock at any speed.
// - A global reset plus separate receive and transmit domain resets.
`ifndef EMR_CFG_SVH
`define EMR_CFG_SVH

// ==========================================================
// frame layout and limits
`define EMR_PIPE_DEPTH 16
`define EMR_MIN_FRAME 14'd64
`define EMR_MAX_FRAME 14'd1518
`define EMR_FC_ETYPE 16'h8808
`define EMR_PAUSE_OPC 16'h0001
`define EMR_PAUSE_DA 48'h0180c2000001

// ==========================================================
// configuration vector fields
`define EMR_RXC_EN 1
`define EMR_RXC_JUMBO 2
`define EMR_RXC_FCEN 5
`define EMR_RXC_PROMISC 9
`define EMR_RXC_ADDR 32
`define EMR_TXC_FCEN 5
`define EMR_RXCFG_RST 80'h0000_0000_0000_0000_0002
`define EMR_TXCFG_RST 80'h0000_0000_0000_0000_0022

// ==========================================================
// statistics vector fields
`define EMR_ST_LEN 0
`define EMR_ST_GOOD 14
`define EMR_ST_BAD 15
`define EMR_ST_BCAST 16
`define EMR_ST_MCAST 17
`define EMR_ST_CTL 18
`define EMR_ST_PAUSE 19
`define EMR_ST_RUNT 20
`define EMR_ST_OVER 21
`define EMR_ST_AV 22

// ==========================================================
// management word offsets
`define EMR_OFF_RX0 12'h000
`define EMR_OFF_RX1 12'h004
`define EMR_OFF_RX2 12'h008
`define EMR_OFF_TX0 12'h00c
`define EMR_OFF_TX1 12'h010
`define EMR_OFF_TX2 12'h014
`define EMR_OFF_STAT 12'h018

// ==========================================================
// timing
`define EMR_MAC_CLK_MHZ 25
`define EMR_QUANTUM_BITS 512
`define EMR_BITS_PER_CYCLE 8
`define EMR_QUANTUM_CYC (`EMR_QUANTUM_BITS / `EMR_BITS_PER_CYCLE)

`endif

// ### emr_pkg.sv
/*
 Types of the receive client port and flow-control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package emr_pkg;
  typedef enum logic {PR_IDLE, PR_WAIT} emr_preq_t;
  typedef logic [1:0] emr_resp_t;
  localparam emr_resp_t EMR_OKAY = 2'h0;
  localparam emr_resp_t EMR_SLVERR = 2'h2;
endpackage : emr_pkg

// ### emr_top.sv
/*
 Receive client streams, statistics, pause handling in both directions,
 management slave and configuration vector capture.
 Assumes a front end that delivers one byte per clock while a frame is
 on the wire, and a transmit engine that reports when it is busy.
*/
`include "emr_cfg.svh"

module emr_top #(
  parameter int NFILT = 4,
  parameter bit AVB_EN = 1'b1,
  parameter bit MGMT_EN = 1'b1,
  parameter logic [15:0] AV_ETYPE = 16'h22f0,
  parameter int AW = AVB_EN ? 17 : 12
) (
  // clock and resets
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rxRstN,
  input wire logic txRstN,
  // receive front end
  input wire logic [7:0] phyByte,
  input wire logic phyValid,
  input wire logic phyErr,
  // filter addresses, filter k at bits [48k+47:48k]
  input wire logic [NFILT*48-1:0] filtAddr,
  // main receive stream
  output logic [7:0] rcvByte,
  output logic rcvValid,
  output logic rcvLast,
  output logic rcvErr,
  output logic [NFILT-1:0] filtReject,
  // statistics
  output logic [27:0] statVec,
  output logic statValid,
  // audio-video receive stream
  output logic [7:0] avRcvStreamByte,
  output logic avRcvValid,
  output logic avRcvLast,
  output logic avRcvErr,
  // flow control
  input wire logic pauseReq,
  input wire logic [15:0] pauseVal,
  input wire logic txBusy,
  output logic txHold,
  output logic pauseSend,
  output logic [15:0] pauseSendVal,
  // configuration vectors and active transmit setup
  input wire logic [79:0] rxCfgVec,
  input wire logic [79:0] txCfgVec,
  output logic [79:0] txCfgActive,
  // management slave
  input wire logic s_axi_resetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output emr_pkg::emr_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output emr_pkg::emr_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import emr_pkg::*;

  localparam int D = `EMR_PIPE_DEPTH;
  localparam int QC = `EMR_QUANTUM_CYC; // one byte per clock
  localparam int QW = $clog2(QC);

  // ==========================================================
  // resets
  logic rxRst;
  logic txRst;
  logic axRst;
  assign rxRst = rst | ~rxRstN;
  assign txRst = rst | ~txRstN;
  assign axRst = rst | ~s_axi_resetn;

  // ==========================================================
  // configuration source
  logic [79:0] rxVecMeta;
  logic [79:0] rxVecReg;
  logic [79:0] txVecMeta;
  logic [79:0] txVecReg;
  logic [79:0] rxCfgReg;
  logic [79:0] txCfgReg;
  logic [79:0] rxCfg;
  logic [79:0] txCfg;

  always_ff @(posedge sys_clk) begin
    rxVecMeta <= rxCfgVec;
    rxVecReg <= rxVecMeta;
    txVecMeta <= txCfgVec;
    txVecReg <= txVecMeta;
  end

  assign rxCfg = MGMT_EN ? rxCfgReg : rxVecReg;
  assign txCfg = MGMT_EN ? txCfgReg : txVecReg;

  always_ff @(posedge sys_clk) begin
    if (txRst) begin
      txCfgActive <= `EMR_TXCFG_RST;
    end else begin
      txCfgActive <= txCfg;
    end
  end

  // ==========================================================
  // input side: frame gating, header capture, delay line
  logic inGate;
  logic inFrameReg;
  logic inEnd;
  logic inErrReg;
  logic [13:0] inCnt;
  logic [47:0] daReg;
  logic [15:0] etypeReg;
  logic [15:0] opcReg;
  logic [15:0] quantaReg;
  logic routeAvReg;
  logic [7:0] pipeByte [D];
  logic [D-1:0] pipeVal;

  // a frame already running when the receiver is disabled is finished
  assign inGate = phyValid & (inFrameReg | rxCfg[`EMR_RXC_EN]);
  assign inEnd = inFrameReg & ~inGate;

  always_ff @(posedge sys_clk) begin
    if (rxRst) begin
      inFrameReg <= 1'b0;
      inErrReg <= 1'b0;
      inCnt <= 14'h0;
      routeAvReg <= 1'b0;
    end else begin
      inFrameReg <= inGate;
      if (!inGate) begin
        inCnt <= 14'h0;
        inErrReg <= 1'b0;
      end else begin
        if (inCnt != 14'h3fff) begin
          inCnt <= inCnt + 14'h1;
        end
        if (phyErr) begin
          inErrReg <= 1'b1;
        end
      end
      if (inGate && !inFrameReg) begin
        routeAvReg <= 1'b0;
      end else if (inGate && inCnt == 14'd14) begin
        routeAvReg <= AVB_EN && etypeReg == AV_ETYPE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rxRst) begin
      daReg <= 48'h0;
      etypeReg <= 16'h0;
      opcReg <= 16'h0;
      quantaReg <= 16'h0;
    end else if (inGate) begin
      if (inCnt < 14'd6) begin
        daReg <= {daReg[39:0], phyByte};
      end
      if (inCnt == 14'd12 || inCnt == 14'd13) begin
        etypeReg <= {etypeReg[7:0], phyByte};
      end
      if (inCnt == 14'd14 || inCnt == 14'd15) begin
        opcReg <= {opcReg[7:0], phyByte};
      end
      if (inCnt == 14'd16 || inCnt == 14'd17) begin
        quantaReg <= {quantaReg[7:0], phyByte};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rxRst) begin
      pipeVal <= '0;
    end else begin
      pipeVal <= {pipeVal[D-2:0], inGate};
    end
  end

  always_ff @(posedge sys_clk) begin
    pipeByte[0] <= phyByte;
    for (int i = 1; i < D; i++) begin
      pipeByte[i] <= pipeByte[i-1];
    end
  end

  // ==========================================================
  // frame verdict at input end
  logic isBcast;
  logic isCtl;
  logic isPause;
  logic isRunt;
  logic isOver;
  logic isBad;
  logic pauseTake;
  logic [NFILT-1:0] filtHit;
  logic resErrReg;
  logic [NFILT-1:0] resFiltReg;
  logic [27:0] resStatReg;

  assign isBcast = daReg == 48'hffff_ffff_ffff;
  assign isCtl = etypeReg == `EMR_FC_ETYPE;
  assign isPause = isCtl && opcReg == `EMR_PAUSE_OPC &&
    (daReg == `EMR_PAUSE_DA || daReg == rxCfg[`EMR_RXC_ADDR +: 48]);
  assign isRunt = inCnt < `EMR_MIN_FRAME;
  assign isOver = !rxCfg[`EMR_RXC_JUMBO] && inCnt > `EMR_MAX_FRAME;
  assign isBad = inErrReg | isRunt | isOver;
  assign pauseTake = inEnd & isPause & ~isBad &
    rxCfg[`EMR_RXC_FCEN];

  always_comb begin
    for (int k = 0; k < NFILT; k++) begin
      filtHit[k] = rxCfg[`EMR_RXC_PROMISC] || isBcast ||
        daReg == filtAddr[k*48 +: 48];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rxRst) begin
      resErrReg <= 1'b0;
      resFiltReg <= '0;
      resStatReg <= 28'h0;
    end else if (inEnd) begin
      resErrReg <= isBad | pauseTake;
      resFiltReg <= ~filtHit;
      resStatReg <= 28'h0;
      resStatReg[`EMR_ST_LEN +: 14] <= inCnt;
      resStatReg[`EMR_ST_GOOD] <= ~isBad;
      resStatReg[`EMR_ST_BAD] <= isBad;
      resStatReg[`EMR_ST_BCAST] <= isBcast;
      resStatReg[`EMR_ST_MCAST] <= daReg[40] & ~isBcast;
      resStatReg[`EMR_ST_CTL] <= isCtl;
      resStatReg[`EMR_ST_PAUSE] <= isPause;
      resStatReg[`EMR_ST_RUNT] <= isRunt;
      resStatReg[`EMR_ST_OVER] <= isOver;
      resStatReg[`EMR_ST_AV] <= routeAvReg;
    end
  end

  // ==========================================================
  // output streams
  logic outHead;
  logic outEnd;
  logic outActReg;
  logic outAvReg;
  logic curAv;
  logic endMain;
  logic endAv;

  assign outHead = pipeVal[D-1];
  assign outEnd = pipeVal[D-1] & ~pipeVal[D-2];
  assign curAv = outActReg ? outAvReg : routeAvReg;
  assign endMain = outEnd & ~curAv;
  assign endAv = outEnd & curAv;

  always_ff @(posedge sys_clk) begin
    if (rxRst) begin
      outActReg <= 1'b0;
      outAvReg <= 1'b0;
    end else begin
      outActReg <= outHead & ~outEnd;
      outAvReg <= curAv;
    end
  end

  // all flags are active high
  always_ff @(posedge sys_clk) begin
    if (rxRst) begin
      rcvByte <= 8'h0;
      rcvValid <= 1'b0;
      rcvLast <= 1'b0;
      rcvErr <= 1'b0;
      filtReject <= '0;
      statVec <= 28'h0;
      statValid <= 1'b0;
    end else begin
      rcvByte <= pipeByte[D-1];
      rcvValid <= outHead & ~curAv;
      rcvLast <= endMain;
      rcvErr <= endMain & resErrReg;
      filtReject <= endMain ? resFiltReg : '0;
      statValid <= outEnd;
      if (outEnd) begin
        statVec <= resStatReg;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rxRst) begin
      avRcvStreamByte <= 8'h0;
      avRcvValid <= 1'b0;
      avRcvLast <= 1'b0;
      avRcvErr <= 1'b0;
    end else begin
      avRcvStreamByte <= AVB_EN ? pipeByte[D-1] : 8'h0;
      avRcvValid <= outHead & curAv;
      avRcvLast <= endAv;
      avRcvErr <= endAv & resErrReg;
    end
  end

  // ==========================================================
  // received pause: transmitter hold timer
  logic [15:0] holdQuanta;
  logic [QW-1:0] holdSub;

  always_ff @(posedge sys_clk) begin
    if (txRst) begin
      holdQuanta <= 16'h0;
      holdSub <= '0;
      txHold <= 1'b0;
    end else begin
      txHold <= holdQuanta != 16'h0;
      if (pauseTake) begin
        holdQuanta <= quantaReg;
        holdSub <= '0;
      end else if (holdQuanta != 16'h0) begin
        holdSub <= holdSub + 1'b1;
        if (holdSub == QW'(QC - 1)) begin
          holdQuanta <= holdQuanta - 16'h1;
        end
      end
    end
  end

  // ==========================================================
  // client pause request
  emr_preq_t preqState;

  always_ff @(posedge sys_clk) begin
    if (txRst) begin
      preqState <= PR_IDLE;
      pauseSend <= 1'b0;
      pauseSendVal <= 16'h0;
    end else begin
      pauseSend <= 1'b0;
      case (preqState)
        PR_IDLE: begin
          if (pauseReq && txCfg[`EMR_TXC_FCEN]) begin
            pauseSendVal <= pauseVal;
            preqState <= PR_WAIT;
          end
        end
        PR_WAIT: begin
          if (!txBusy) begin
            pauseSend <= 1'b1;
            preqState <= PR_IDLE;
          end
          // a request during the send is kept
          if (pauseReq && txCfg[`EMR_TXC_FCEN]) begin
            pauseSendVal <= pauseVal;
            preqState <= PR_WAIT;
          end
        end
        default: preqState <= PR_IDLE;
      endcase
    end
  end

  // ==========================================================
  // management slave
  logic wrHit;
  logic rdHit;
  logic [31:0] rdWord;

  function automatic logic isOff(input logic [AW-1:0] a,
                                 input logic [11:0] off);
    isOff = a == AW'(off);
  endfunction : isOff

  assign wrHit = isOff(s_axi_awaddr, `EMR_OFF_RX0) ||
    isOff(s_axi_awaddr, `EMR_OFF_RX1) || isOff(s_axi_awaddr, `EMR_OFF_RX2) ||
    isOff(s_axi_awaddr, `EMR_OFF_TX0) || isOff(s_axi_awaddr, `EMR_OFF_TX1) ||
    isOff(s_axi_awaddr, `EMR_OFF_TX2) || isOff(s_axi_awaddr, `EMR_OFF_STAT);

  always_comb begin
    rdHit = 1'b1;
    rdWord = 32'h0;
    if (isOff(s_axi_araddr, `EMR_OFF_RX0)) rdWord = rxCfgReg[31:0];
    else if (isOff(s_axi_araddr, `EMR_OFF_RX1)) rdWord = rxCfgReg[63:32];
    else if (isOff(s_axi_araddr, `EMR_OFF_RX2))
      rdWord = {16'h0, rxCfgReg[79:64]};
    else if (isOff(s_axi_araddr, `EMR_OFF_TX0)) rdWord = txCfgReg[31:0];
    else if (isOff(s_axi_araddr, `EMR_OFF_TX1)) rdWord = txCfgReg[63:32];
    else if (isOff(s_axi_araddr, `EMR_OFF_TX2))
      rdWord = {16'h0, txCfgReg[79:64]};
    else if (isOff(s_axi_araddr, `EMR_OFF_STAT))
      rdWord = {holdQuanta, 14'h0, preqState == PR_WAIT, txHold};
    else rdHit = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (axRst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= EMR_OKAY;
      rxCfgReg <= `EMR_RXCFG_RST;
      txCfgReg <= `EMR_TXCFG_RST;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
          !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? EMR_OKAY : EMR_SLVERR;
        if (isOff(s_axi_awaddr, `EMR_OFF_RX0)) rxCfgReg[31:0] <= s_axi_wdata;
        if (isOff(s_axi_awaddr, `EMR_OFF_RX1)) rxCfgReg[63:32] <= s_axi_wdata;
        if (isOff(s_axi_awaddr, `EMR_OFF_RX2))
          rxCfgReg[79:64] <= s_axi_wdata[15:0];
        if (isOff(s_axi_awaddr, `EMR_OFF_TX0)) txCfgReg[31:0] <= s_axi_wdata;
        if (isOff(s_axi_awaddr, `EMR_OFF_TX1)) txCfgReg[63:32] <= s_axi_wdata;
        if (isOff(s_axi_awaddr, `EMR_OFF_TX2))
          txCfgReg[79:64] <= s_axi_wdata[15:0];
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (axRst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= EMR_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdWord;
        s_axi_rresp <= rdHit ? EMR_OKAY : EMR_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // checks
  property p_last_err;
    @(posedge sys_clk) disable iff (rxRst) rcvErr |-> rcvLast && rcvValid;
  endproperty
  a_last_err: assert property (p_last_err) else $error("bad err");

  property p_stat_end;
    @(posedge sys_clk) disable iff (rxRst)
      (rcvLast || avRcvLast) |-> statValid;
  endproperty
  a_stat_end: assert property (p_stat_end) else $error("stat late");

  property p_stat_pulse;
    @(posedge sys_clk) disable iff (rxRst) statValid |=> !statValid;
  endproperty
  a_stat_pulse: assert property (p_stat_pulse) else $error("wide");

  property p_one_stream;
    @(posedge sys_clk) disable iff (rxRst) !(rcvValid && avRcvValid);
  endproperty
  a_one_stream: assert property (p_one_stream) else $error("both");

  property p_last_valid;
    @(posedge sys_clk) disable iff (rxRst) rcvLast |-> rcvValid;
  endproperty
  a_last_valid: assert property (p_last_valid) else $error("last");

  property p_take_hold;
    @(posedge sys_clk) disable iff (txRst)
      pauseTake && quantaReg != 16'h0 |-> ##2 txHold;
  endproperty
  a_take_hold: assert property (p_take_hold) else $error("no hold");

  property p_take_err;
    @(posedge sys_clk) disable iff (rxRst) pauseTake |=> resErrReg;
  endproperty
  a_take_err: assert property (p_take_err) else $error("pause ok");

  property p_send_idle;
    @(posedge sys_clk) disable iff (txRst) pauseSend |-> !$past(txBusy);
  endproperty
  a_send_idle: assert property (p_send_idle) else $error("busy");

  sequence s_req;
    preqState == PR_IDLE && pauseReq && txCfg[`EMR_TXC_FCEN];
  endsequence
  property p_req_val;
    @(posedge sys_clk) disable iff (txRst)
      s_req |=> pauseSendVal == $past(pauseVal);
  endproperty
  a_req_val: assert property (p_req_val) else $error("value");

  property p_bresp;
    @(posedge sys_clk) disable iff (axRst)
      s_axi_awready && wrHit |=> s_axi_bvalid && s_axi_bresp == EMR_OKAY;
  endproperty
  a_bresp: assert property (p_bresp) else $error("bresp");

endmodule : emr_top

// ### emr_tx_model.sv
/*
 Stand-in for the transmit engine beside the pause logic.
 Assumes one clock shared with the block and an active-high reset.
*/
module emr_tx_model #(
  parameter int FLEN = 30
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // frame start from the bench, pause handshake from the block
  input wire logic go,
  input wire logic txHold,
  input wire logic pauseSend,
  // engine state
  output logic txBusy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] busyCnt_reg;

  // ==========================================================
  // frame timer: no new frame while held, pause frames occupy the line
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busyCnt_reg <= 8'h00;
    end else if (busyCnt_reg != 8'h00) begin
      busyCnt_reg <= busyCnt_reg - 8'h01;
    end else if ((go || pauseSend) && !txHold) begin
      busyCnt_reg <= 8'(FLEN);
    end
  end
  assign txBusy = busyCnt_reg != 8'h00;
endmodule : emr_tx_model

// ### emr_top_test.sv
/*
 Self-checking bench for the receive client ports and flow control.
 Assumes emr_top with defaults, management port present, one clock.
*/
module emr_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import emr_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, rxRstN = 1'b1, txRstN = 1'b1;
  logic [7:0] phyByte = 8'h00;
  logic phyValid = 1'b0, phyErr = 1'b0, pauseReq = 1'b0, txBusy, go = 1'b0;
  logic [191:0] filtAddr = {48'h4, 48'h3, 48'h2, 48'h0a0b0c0d0e0f};
  logic [7:0] rcvByte, avRcvStreamByte;
  logic rcvValid, rcvLast, rcvErr, avRcvValid, avRcvLast, avRcvErr;
  logic [3:0] filtReject, lastFilt;
  logic [27:0] statVec, lastStat;
  logic statValid, txHold, pauseSend, lastErr, avErr;
  logic [15:0] pauseVal = 16'h0000, pauseSendVal, fEt, fP;
  logic [79:0] rxCfgVec = 80'h2, txCfgVec = 80'h22, txCfgActive;
  logic s_axi_resetn = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [16:0] s_axi_awaddr = 17'h0, s_axi_araddr = 17'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  emr_resp_t s_axi_bresp, s_axi_rresp, r;
  logic [47:0] fDa;
  logic [7:0] rxQ[$], avQ[$];
  int errors = 0, cmp_count = 0, lastIdx, n;

  always #20 sys_clk = ~sys_clk;

  emr_top uut (.sys_clk, .rst, .rxRstN, .txRstN, .phyByte, .phyValid,
    .phyErr, .filtAddr, .rcvByte, .rcvValid, .rcvLast, .rcvErr, .filtReject,
    .statVec, .statValid, .avRcvStreamByte, .avRcvValid, .avRcvLast,
    .avRcvErr, .pauseReq, .pauseVal, .txBusy, .txHold, .pauseSend,
    .pauseSendVal, .rxCfgVec, .txCfgVec, .txCfgActive, .s_axi_resetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  emr_tx_model txm (.sys_clk, .rst, .go, .txHold, .pauseSend, .txBusy);

  // ==========================================================
  // stream monitors
  always @(posedge sys_clk) begin
    if (rcvLast === 1'b1) begin
      lastIdx = rxQ.size();
      lastErr = rcvErr;
      lastFilt = filtReject;
    end
    if (rcvValid === 1'b1) rxQ.push_back(rcvByte);
    if (avRcvValid === 1'b1) avQ.push_back(avRcvStreamByte);
    if (avRcvLast === 1'b1) avErr = avRcvErr;
    if (statValid === 1'b1) lastStat = statVec;
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] fb(input int i);
    if (i < 6) return fDa[47-8*i -: 8];
    if (i < 12) return 8'h02;
    case (i)
      12: return fEt[15:8];
      13: return fEt[7:0];
      14: return 8'h00;
      15: return 8'h01;
      16: return fP[15:8];
      17: return fP[7:0];
      default: return i[7:0];
    endcase
  endfunction : fb

  task automatic send(input logic [47:0] da, input logic [15:0] et, p,
                      input int len, input logic er);
    fDa = da;
    fEt = et;
    fP = p;
    rxQ.delete();
    avQ.delete();
    for (int i = 0; i < len; i++) begin
      @(posedge sys_clk);
      phyValid <= 1'b1;
      phyByte <= fb(i);
      phyErr <= er && (i == len - 1);
    end
    @(posedge sys_clk);
    phyValid <= 1'b0;
    phyErr <= 1'b0;
    repeat (24) @(posedge sys_clk);
  endtask : send

  task automatic axi_wr(input logic [16:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 20 && s_axi_awready !== 1'b1; n++) @(posedge sys_clk);
    if (n == 20) errors++;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    for (n = 0; n < 20 && s_axi_bvalid !== 1'b1; n++) @(posedge sys_clk);
    if (n == 20) errors++;
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [16:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 20 && s_axi_arready !== 1'b1; n++) @(posedge sys_clk);
    if (n == 20) errors++;
    s_axi_arvalid <= 1'b0;
    for (n = 0; n < 20 && s_axi_rvalid !== 1'b1; n++) @(posedge sys_clk);
    if (n == 20) errors++;
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic report_and_stop;
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // watchdog
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    report_and_stop();
  end

  // ==========================================================
  // tests
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk(32'(txCfgActive), 32'h22);
    axi_rd(17'h0);
    chk(d, 32'h2);
    chk(32'(r), 32'(EMR_OKAY));
    axi_wr(17'h0, 32'h22);
    chk(32'(r), 32'(EMR_OKAY));
    axi_rd(17'h0);
    chk(d, 32'h22);
    axi_rd(17'h100);
    chk(32'(r), 32'(EMR_SLVERR));
    // good frame to filter 0
    send(48'h0a0b0c0d0e0f, 16'h0800, 16'h0, 64, 1'b0);
    chk(rxQ.size(), 64);
    chk(32'(rxQ[5]), 32'h0f);
    chk(32'(rxQ[63]), 32'h3f);
    chk(lastIdx, 63);
    chk(32'(lastErr), 32'h0);
    chk(32'(lastFilt), 32'he);
    chk(32'(lastStat[15:0]), 32'h4040);
    // runt, then line error
    send(48'h0a0b0c0d0e0f, 16'h0800, 16'h0, 20, 1'b0);
    chk(32'(lastErr), 32'h1);
    chk(32'(lastStat[20]), 32'h1);
    send(48'h0a0b0c0d0e0f, 16'h0800, 16'h0, 64, 1'b1);
    chk(32'(lastErr), 32'h1);
    chk(32'(lastStat[15]), 32'h1);
    // audio-video frame
    send(48'h0a0b0c0d0e0f, 16'h22f0, 16'h0, 64, 1'b0);
    chk(avQ.size(), 64);
    chk(32'(avQ[5]), 32'h0f);
    chk(32'(avQ[63]), 32'h3f);
    chk(rxQ.size(), 0);
    chk(32'(avErr), 32'h0);
    chk(32'(lastStat[22]), 32'h1);
    // pause frame of two quanta
    send(48'h0180c2000001, 16'h8808, 16'h0002, 64, 1'b0);
    chk(32'(lastErr), 32'h1);
    chk(32'(lastStat[19]), 32'h1);
    axi_rd(17'h18);
    chk(32'(d[0]), 32'h1);
    repeat (85) @(posedge sys_clk);
    chk(32'(txHold), 32'h1);
    repeat (30) @(posedge sys_clk);
    chk(32'(txHold), 32'h0);
    // pause request while a frame is on the line
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (3) @(posedge sys_clk);
    pauseReq <= 1'b1;
    pauseVal <= 16'h1234;
    @(posedge sys_clk);
    pauseReq <= 1'b0;
    for (n = 0; n < 100 && pauseSend !== 1'b1; n++) @(posedge sys_clk);
    chk(n, 28);
    chk(32'(txBusy), 32'h0);
    chk(32'(pauseSendVal), 32'h1234);
    repeat (40) @(posedge sys_clk);
    // domain resets in mid-run
    rxRstN <= 1'b0;
    txRstN <= 1'b0;
    s_axi_resetn <= 1'b0;
    @(posedge sys_clk);
    rxRstN <= 1'b1;
    txRstN <= 1'b1;
    s_axi_resetn <= 1'b1;
    @(posedge sys_clk);
    chk(32'(statVec), 32'h0);
    chk(32'(pauseSendVal), 32'h0);
    axi_rd(17'h0);
    chk(d, 32'h2);
    report_and_stop();
  end
endmodule : emr_top_test
